// *** direction_decision.sv ***
// Purpose: Registered pickup decision for the selected direction mode
// Assumes: Current phasor angle is referred to the polarising residual voltage
// Notes:   Pickup and sector comparisons use a common Q15-scaled signed domain; floor checks compare raw magnitudes
`timescale 1ns/1ns
`default_nettype none
module direction_decision
    import residual_dir_pkg::*;
#(
    parameter int W = PHASOR_W
)(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire dir_mode_t           direction_select,     // Mode setting
    input  wire logic signed [W-1:0] cur_re,               // |3Io|*cos(fi)
    input  wire logic signed [W-1:0] cur_im,               // |3Io|*sin(fi)
    input  wire logic        [W-1:0] cur_mag,              // |3Io|
    input  wire logic        [W-1:0] volt_mag,             // |3Uo|
    input  wire logic        [W-1:0] pickup_current,       // Start current
    input  wire logic        [W-1:0] min_residual_current, // Operation floor
    input  wire logic        [W-1:0] min_residual_voltage, // Directionality floor
    input  wire logic signed [15:0]  rca_cos,              // Cos of characteristic angle
    input  wire logic signed [15:0]  rca_sin,              // Sin of characteristic angle
    input  wire logic        [15:0]  roa_cos,              // Cos of operating half angle
    output logic                     cond                  // Pickup condition met
);
    localparam int P = 2*W+2;                 // Working width

    logic signed [P-1:0] re_q;                // Real part scaled
    logic signed [P-1:0] im_q;                // Imag part scaled
    logic signed [P-1:0] diag_q;              // Projection on 45 degree line
    logic signed [P-1:0] pick_q;              // Pickup scaled
    logic signed [P-1:0] mag_q;               // Magnitude scaled
    logic signed [P-1:0] proj_q;              // Projection on characteristic line
    logic signed [P-1:0] lim_q;               // Boundary of the operate sector
    logic                volt_ok;             // Voltage above its floor
    logic                curr_ok;             // Current not below its floor
    logic                next_cond;           // Unregistered decision

    // Scaled operands
    always_comb
    begin
        re_q   = P'(cur_re) <<< COEF_FRAC;
        im_q   = P'(cur_im) <<< COEF_FRAC;
        diag_q = (P'(cur_re) + P'(cur_im)) * $signed(P'(DIAG_COEF));
        pick_q = $signed(P'(pickup_current)) <<< COEF_FRAC;
        mag_q  = $signed(P'(cur_mag)) <<< COEF_FRAC;
        proj_q = P'(cur_re) * P'(rca_cos) + P'(cur_im) * P'(rca_sin);
        lim_q  = $signed(P'(cur_mag)) * $signed(P'(roa_cos));
    end

    // Mode decision
    always_comb
    begin
        volt_ok = volt_mag > min_residual_voltage;
        curr_ok = cur_mag >= min_residual_current;
        case (direction_select)
            DIR_NONDIR:    next_cond = mag_q > pick_q;
            DIR_FWD_ANGLE: next_cond = volt_ok && proj_q > lim_q
                                       && mag_q > pick_q;
            DIR_BWD_ANGLE: next_cond = volt_ok && -proj_q > lim_q
                                       && mag_q > pick_q;
            DIR_FWD_COS:   next_cond = volt_ok && re_q > pick_q;
            DIR_BWD_COS:   next_cond = volt_ok && -re_q > pick_q;
            DIR_FWD_SIN:   next_cond = volt_ok && im_q > pick_q;
            DIR_BWD_SIN:   next_cond = volt_ok && -im_q > pick_q;
            DIR_FWD_SIN45: next_cond = volt_ok && diag_q > pick_q;
            DIR_BWD_SIN45: next_cond = volt_ok && -diag_q > pick_q;
            default:       next_cond = 1'b0;
        endcase
        next_cond = next_cond && curr_ok;
    end

    // Decision register
    always_ff @(posedge mclk)
    begin
        if (rst)
            cond <= 1'b0;
        else
            cond <= next_cond;
    end

    // Low voltage blocks any directional pickup
    property p_volt_floor;
        @(posedge mclk) disable iff (rst)
        (direction_select != DIR_NONDIR && volt_mag <= min_residual_voltage) |=> !cond;
    endproperty
    a_volt_floor: assert property (p_volt_floor) else $error("pickup under low voltage");

    // Low current blocks pickup
    property p_curr_floor;
        @(posedge mclk) disable iff (rst)
        (cur_mag < min_residual_current) |=> !cond;
    endproperty
    a_curr_floor: assert property (p_curr_floor) else $error("pickup under low current");

    // Forward cosine needs real part above pickup
    property p_fwd_cos;
        @(posedge mclk) disable iff (rst)
        (direction_select == DIR_FWD_COS && $signed({1'b0, pickup_current}) >= cur_re)
        |=> !cond;
    endproperty
    a_fwd_cos: assert property (p_fwd_cos) else $error("cosine pickup too low");

    // Backward sine needs a negative imaginary part
    property p_bwd_sin;
        @(posedge mclk) disable iff (rst)
        (direction_select == DIR_BWD_SIN && cur_im >= 0) |=> !cond;
    endproperty
    a_bwd_sin: assert property (p_bwd_sin) else $error("backward sine wrong side");

    // Nondirectional picks up on magnitude alone
    property p_nondir;
        @(posedge mclk) disable iff (rst)
        (direction_select == DIR_NONDIR && cur_mag > pickup_current
         && cur_mag >= min_residual_current) |=> cond;
    endproperty
    a_nondir: assert property (p_nondir) else $error("nondirectional missed");
endmodule // direction_decision
`default_nettype wire

// *** directional_residual_overcurrent.sv ***
// Purpose: Directional residual overcurrent start and trip decision
// Assumes: Settings are static ports already scaled to phasor units
// Notes:   Inverse-time curves are not provided; only the definite delay
// Notes on behaviour
// - Start flag follows met pickup conditions
// - Trip flag carries the function's trip command
// - Block input suppresses start and trip
// - Current phasor must lie in operate region
// - Angle modes need magnitude above pickup
// - Directional modes need voltage above minimum
// - Forward cosine: real projection above pickup
// - Backward cosine: negative real projection above pickup
// - Forward sine: imaginary projection above pickup
// - Backward sine: negative imaginary projection above pickup
// - Forward 45: projection on 45 line above pickup
// - Backward 45: projection on 225 line above pickup
// - Nine direction modes, forward angle default
// - Low residual voltage forbids directional decisions
// - Low residual current forbids any operation
`timescale 1ns/1ns
`default_nettype none
module directional_residual_overcurrent
    import residual_dir_pkg::*;
#(
    parameter int W      = PHASOR_W,
    parameter int CYC_MS = CYC_PER_MS           // Cycles in one millisecond
)(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                block_input,          // Suppresses the function
    input  wire dir_mode_t           direction_select,     // Direction mode
    input  wire logic signed [W-1:0] cur_re,               // Residual current real part
    input  wire logic signed [W-1:0] cur_im,               // Residual current imag part
    input  wire logic        [W-1:0] cur_mag,              // Residual current magnitude
    input  wire logic        [W-1:0] volt_mag,             // Residual voltage magnitude
    input  wire logic        [W-1:0] pickup_current,       // Start current
    input  wire logic        [W-1:0] min_residual_current, // Current floor
    input  wire logic        [W-1:0] min_residual_voltage, // Voltage floor
    input  wire logic signed [15:0]  rca_cos,              // Characteristic angle cosine
    input  wire logic signed [15:0]  rca_sin,              // Characteristic angle sine
    input  wire logic        [15:0]  roa_cos,              // Operating half angle cosine
    input  wire logic [DELAY_W-1:0]  delay_ms,             // Definite delay in ms
    output logic                     general_start_flag,   // Start indication
    output logic                     general_trip_flag     // Trip command
);
    logic cond;                                 // Pickup met, one cycle late
    logic run;                                  // Start condition unblocked
    logic done;                                 // Delay elapsed

    // Pickup decision per mode
    direction_decision #(
        .W                   (W)
    ) u_decision (
        .mclk                (mclk),
        .rst                 (rst),
        .direction_select    (direction_select),
        .cur_re              (cur_re),
        .cur_im              (cur_im),
        .cur_mag             (cur_mag),
        .volt_mag            (volt_mag),
        .pickup_current      (pickup_current),
        .min_residual_current(min_residual_current),
        .min_residual_voltage(min_residual_voltage),
        .rca_cos             (rca_cos),
        .rca_sin             (rca_sin),
        .roa_cos             (roa_cos),
        .cond                (cond)
    );

    // Start gated by the block input
    assign run = cond && !block_input;

    // Definite delay toward trip
    time_delay_stage #(
        .CYC_MS              (CYC_MS)
    ) u_delay (
        .mclk                (mclk),
        .rst                 (rst),
        .run                 (run),
        .delay_ms            (delay_ms),
        .done                (done)
    );

    // Start flag register
    always_ff @(posedge mclk)
    begin
        if (rst)
            general_start_flag <= 1'b0;
        else
            general_start_flag <= run;
    end

    // Trip flag register
    always_ff @(posedge mclk)
    begin
        if (rst)
            general_trip_flag <= 1'b0;
        else
            general_trip_flag <= run && done;
    end

    // Helper: length of the current unbroken start run
    logic [31:0] run_len;                       // Cycles start has held
    always_ff @(posedge mclk)
    begin
        if (rst || !run)
            run_len <= '0;
        else if (run_len != 32'hffffffff)
            run_len <= run_len + 32'h1;
    end

    // Pickup and release sequences
    sequence s_pick;
        cond && !block_input;
    endsequence

    sequence s_drop;
        !cond || block_input;
    endsequence

    // Start follows an unblocked pickup
    property p_start;
        @(posedge mclk) disable iff (rst)
        s_pick |=> general_start_flag;
    endproperty
    a_start: assert property (p_start) else $error("start missed");

    // Start and trip clear one cycle after a drop
    property p_drop;
        @(posedge mclk) disable iff (rst)
        s_drop |=> !general_start_flag && !general_trip_flag;
    endproperty
    a_drop: assert property (p_drop) else $error("flags held after drop");

    // Held block keeps both flags low
    property p_block;
        @(posedge mclk) disable iff (rst)
        block_input [*2] |-> !general_start_flag && !general_trip_flag;
    endproperty
    a_block: assert property (p_block) else $error("flag while blocked");

    // Trip never stands without start
    property p_trip_start;
        @(posedge mclk) disable iff (rst)
        general_trip_flag |-> general_start_flag;
    endproperty
    a_trip_start: assert property (p_trip_start) else $error("trip without start");

    // Trip rises only once the delay has run
    property p_trip_delay;
        @(posedge mclk) disable iff (rst)
        $rose(general_trip_flag) |-> run_len >= 32'(CYC_MS) * 32'(delay_ms);
    endproperty
    a_trip_delay: assert property (p_trip_delay) else $error("trip too early");
endmodule // directional_residual_overcurrent
`default_nettype wire

// *** directional_residual_overcurrent_tb.sv ***
// Purpose: Self-checking bench for the residual overcurrent decision
// Assumes: One clock, synchronous reset, settings as plain ports
// Notes:   Millisecond count shortened through CYC_MS
`timescale 1ns/1ns
`default_nettype none
module directional_residual_overcurrent_tb
    import residual_dir_pkg::*;
;
    localparam int          CYC   = 4;        // Cycles per ms in simulation
    localparam logic [15:0] MIN_I = 16'h0032; // Current floor
    localparam logic [15:0] MIN_V = 16'h0014; // Voltage floor
    logic               mclk = 1'b0;     // Bench clock, one driver
    logic               rst, want_blk, block_input, near;
    logic               general_start_flag, general_trip_flag;
    logic signed [15:0] want_re, want_im, cur_re, cur_im;
    logic        [15:0] want_mag, want_volt, cur_mag, volt_mag, pick, delay;
    logic        [31:0] seed;            // Xorshift state
    logic        [1:0]  notes[$];        // Expected results, kind then value
    logic        [1:0]  nt;              // Note under comparison
    dir_mode_t          mode;            // Direction setting
    int                 fail_count, compares;
    event               chk_ev;          // A result is due
    // Free-running clock
    always #4 mclk = ~mclk;
    phasor_source phasor_source_i (.mclk(mclk), .rst(rst), .want_re(want_re),
        .want_im(want_im), .want_mag(want_mag), .want_volt(want_volt), .want_blk(want_blk),
        .cur_re(cur_re), .cur_im(cur_im), .cur_mag(cur_mag), .volt_mag(volt_mag),
        .block_input(block_input));
    directional_residual_overcurrent #(.CYC_MS(CYC)) directional_residual_overcurrent_i (
        .mclk(mclk), .rst(rst), .block_input(block_input), .direction_select(mode),
        .cur_re(cur_re), .cur_im(cur_im), .cur_mag(cur_mag), .volt_mag(volt_mag),
        .pickup_current(pick), .min_residual_current(MIN_I), .min_residual_voltage(MIN_V),
        .rca_cos(16'sh7fff), .rca_sin(16'sh0000), .roa_cos(16'h4000), .delay_ms(delay),
        .general_start_flag(general_start_flag), .general_trip_flag(general_trip_flag));
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Strict compare, flags values too close to call
    function automatic logic gt(longint a, longint b);
        if ((a - b < 64'sd65536) && (b - a < 64'sd65536))
            near = 1'b1;
        return a > b;
    endfunction
    // Reference decision, all sides scaled by 2^15 except the raw current floor check
    function automatic logic ref_cond(logic [3:0] md, longint re, longint im, longint m,
                                      longint v);
        longint s;
        logic   d;
        logic   c;
        s = 32768;
        d = gt(v * s, longint'(MIN_V) * s);
        case (md)
            4'h0: c = gt(m * s, longint'(pick) * s);
            4'h1: c = d && gt(m * s, longint'(pick) * s) && gt(re * 32767, m * 16384);
            4'h2: c = d && gt(m * s, longint'(pick) * s) && gt(-re * 32767, m * 16384);
            4'h3: c = d && gt(re * s, longint'(pick) * s);
            4'h4: c = d && gt(-re * s, longint'(pick) * s);
            4'h5: c = d && gt(im * s, longint'(pick) * s);
            4'h6: c = d && gt(-im * s, longint'(pick) * s);
            4'h7: c = d && gt((re + im) * 23170, longint'(pick) * s);
            4'h8: c = d && gt(-(re + im) * 23170, longint'(pick) * s);
            default: c = 1'b0;
        endcase
        return c && (m >= longint'(MIN_I));
    endfunction
    // Compare tasks, one per result kind
    task automatic chk_start(logic e);
        compares++;
        if (general_start_flag !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t start flag %b expected %b", $time, general_start_flag, e);
        end
    endtask
    task automatic chk_trip(logic e);
        compares++;
        if (general_trip_flag !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t trip flag %b expected %b", $time, general_trip_flag, e);
        end
    endtask
    // Watcher takes the oldest note when a result is due
    always
    begin
        @(chk_ev);
        nt = notes.pop_front();
        if (nt[1])
            chk_trip(nt[0]);
        else
            chk_start(nt[0]);
    end
    // Record an expected result and hand it to the watcher
    task automatic note(logic kind, logic e);
        notes.push_back({kind, e});
        -> chk_ev;
        #1;
    endtask
    // Set new front end values just after an edge
    task automatic apply(logic [3:0] md, int re, int im, int m, int v, logic b);
        @(posedge mclk);
        #1;
        mode      = dir_mode_t'(md);
        want_re   = 16'(re);
        want_im   = 16'(im);
        want_mag  = 16'(m);
        want_volt = 16'(v);
        want_blk  = b;
    endtask
    // Random phasor, mode, pickup and block; start seen three edges later
    task automatic rand_step();
        logic [31:0] r;
        logic [31:0] q;
        logic        e;
        near = 1'b1;
        for (int k = 0; k < 20 && near; k++)
        begin
            near = 1'b0;
            r = rnd();
            q = rnd();
            pick = 16'h0064 + 16'(q[20:13]);
            e = ref_cond(4'(q[9:6] % 10), int'(r[9:0]) - 512, int'(r[19:10]) - 512,
                         int'(r[29:20]), int'(q[5:0])) && (q[12:10] != 3'h0);
        end
        apply(4'(q[9:6] % 10), int'(r[9:0]) - 512, int'(r[19:10]) - 512, int'(r[29:20]),
              int'(q[5:0]), q[12:10] == 3'h0);
        repeat (3) @(posedge mclk);
        #1;
        note(1'b0, e);
    endtask
    // Held pickup trips after the delay, then block or drop clears it
    task automatic trip_case(logic cut);
        int n;
        apply(4'h0, 0, 0, 0, 0, 1'b0);
        repeat (4) @(posedge mclk);
        apply(4'h0, 0, 0, 500, 0, 1'b0);
        repeat (CYC * int'(delay)) @(posedge mclk);
        #1;
        note(1'b1, 1'b0);
        n = 0;
        while (general_trip_flag !== 1'b1 && n < 8)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        // Trip is due exactly three edges into the window
        compares++;
        if (n != 3)
        begin
            fail_count++;
            $display("[FAIL] %0t trip seen %0d edges into the window, 3 due", $time, n);
        end
        if (n == 8)
            test_done();
        note(1'b1, 1'b1);
        note(1'b0, 1'b1);
        apply(4'h0, 0, 0, cut ? 500 : 0, 0, cut);
        repeat (cut ? 2 : 3) @(posedge mclk);
        #1;
        note(1'b1, 1'b0);
        note(1'b0, 1'b0);
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        rst = 1'b1;
        {want_re, want_im, want_mag, want_volt, want_blk} = '0;
        mode = DIR_DEFAULT;
        pick = 16'h00c8;
        delay = 16'h0002;
        seed = 32'h5887d111;
        fail_count = 0;
        compares = 0;
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;
        note(1'b0, 1'b0);
        note(1'b1, 1'b0);
        for (int i = 0; i < 300; i++)
            rand_step();
        trip_case(1'b0);
        // Mid-run reset while start stands clears the start flag
        apply(4'h0, 0, 0, 500, 0, 1'b0);
        repeat (3) @(posedge mclk);
        #1;
        note(1'b0, 1'b1);
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        note(1'b0, 1'b0);
        rst = 1'b0;
        delay = 16'h0003;
        trip_case(1'b1);
        test_done();
    end
endmodule // directional_residual_overcurrent_tb
`default_nettype wire

// *** phasor_source.sv ***
// Purpose: Model of the phasor front end and of the user blocking logic
// Assumes: Bench sets the wanted values shortly after a rising edge
// Notes:   Values reach the block one edge after they are set
`timescale 1ns/1ns
`default_nettype none
module phasor_source
(
    input  wire logic               mclk,        // Processing clock
    input  wire logic               rst,         // Synchronous reset
    input  wire logic signed [15:0] want_re,     // Wanted current real part
    input  wire logic signed [15:0] want_im,     // Wanted current imag part
    input  wire logic        [15:0] want_mag,    // Wanted current magnitude
    input  wire logic        [15:0] want_volt,   // Wanted voltage magnitude
    input  wire logic               want_blk,    // Wanted block level
    output logic signed      [15:0] cur_re,      // Current real part
    output logic signed      [15:0] cur_im,      // Current imag part
    output logic             [15:0] cur_mag,     // Current magnitude
    output logic             [15:0] volt_mag,    // Voltage magnitude
    output logic                    block_input  // User block level
);
    // One fresh sample per edge, quiet phasors and no block in reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cur_re      <= 16'sh0000;
            cur_im      <= 16'sh0000;
            cur_mag     <= 16'h0000;
            volt_mag    <= 16'h0000;
            block_input <= 1'b0;
        end
        else
        begin
            cur_re      <= want_re;
            cur_im      <= want_im;
            cur_mag     <= want_mag;
            volt_mag    <= want_volt;
            block_input <= want_blk;
        end
    end
endmodule // phasor_source
`default_nettype wire

// *** residual_dir_pkg.sv ***
// Purpose: Shared constants and types for the directional residual overcurrent block
// Assumes: Phasor front end delivers fixed-point values on the system clock
// Notes:   Timing counts derive from the 125 MHz processing clock
package residual_dir_pkg;
    // Data widths
    localparam int PHASOR_W      = 16;               // Phasor component width
    localparam int COEF_FRAC     = 15;               // Fraction bits of Q15 coefficients
    localparam int DELAY_W       = 16;               // Delay setting width in ms
    // Projection onto the 45 and 225 degree lines, 1/sqrt(2) in Q15
    localparam logic [15:0] DIAG_COEF = 16'h5a82;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;                // Period of mclk
    localparam int MS_IN_NS      = 1000000;          // One millisecond
    localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
    localparam logic [DELAY_W-1:0] DEF_DELAY_MS = 16'h0064; // Default definite delay, 100 ms
    // Threshold settings in percent of rated values
    localparam int MIN_V_MIN_PCT = 1;                // Min residual voltage range low
    localparam int MIN_V_MAX_PCT = 20;               // Min residual voltage range high
    localparam int MIN_V_DEF_PCT = 2;                // Min residual voltage default
    localparam int MIN_I_MIN_PCT = 1;                // Min residual current range low
    localparam int MIN_I_MAX_PCT = 50;               // Min residual current range high
    localparam int MIN_I_DEF_PCT = 5;                // Min residual current default
    localparam int PICKUP_DEF_PCT = 50;              // Pickup current default
    // Direction modes
    typedef enum logic [3:0] {
        DIR_NONDIR,
        DIR_FWD_ANGLE,
        DIR_BWD_ANGLE,
        DIR_FWD_COS,
        DIR_BWD_COS,
        DIR_FWD_SIN,
        DIR_BWD_SIN,
        DIR_FWD_SIN45,
        DIR_BWD_SIN45
    } dir_mode_t;
    localparam dir_mode_t DIR_DEFAULT = DIR_FWD_ANGLE; // Mode after setup
endpackage

// *** time_delay_stage.sv ***
// Purpose: Definite time delay counted in milliseconds
// Assumes: Run input is a registered start condition
// Notes:   Counters clear as soon as run falls, so trip drops with start
`timescale 1ns/1ns
`default_nettype none
module time_delay_stage
    import residual_dir_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
)(
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               run,        // Start condition held
    input  wire logic [DELAY_W-1:0] delay_ms,   // Delay setting
    output logic                    done        // Delay elapsed
);
    logic [31:0]        pre;                    // Cycles within one ms
    logic [DELAY_W-1:0] ms;                     // Elapsed milliseconds
    logic               tick;                   // Last cycle of a ms

    assign tick = pre == 32'(CYC_MS - 1);

    // Prescaler and ms counter
    always_ff @(posedge mclk)
    begin
        if (rst || !run)
        begin
            pre <= '0;
            ms  <= '0;
        end
        else if (!done)
        begin
            pre <= tick ? '0 : pre + 32'h1;
            if (tick)
                ms <= ms + 16'h1;
        end
    end

    // Elapsed flag
    always_ff @(posedge mclk)
    begin
        if (rst || !run)
            done <= 1'b0;
        else if (tick && (17'(ms) + 17'h1 >= 17'(delay_ms)))
            done <= 1'b1;
    end
endmodule // time_delay_stage
`default_nettype wire
